// file: bench/alfc_props.sv
// Property checker for the link fault continuity top, on its ports only.
// Assumes one clock and the power-on reset as the only reset.
`timescale 1ns/10ps
module alfc_props #(
    parameter NL = 6
) (
    input wire          clock_in,
    input wire          rst_in,
    input wire          cpu_reset_in,
    input wire          timer_enable_in,
    input wire          resync_enable_in,
    input wire          sync_burst_in,
    input wire          frame_event_out,
    input wire          timer_running_out,
    input wire [NL-1:0] rx_enable_in,
    input wire [NL-1:0] rx_clock_alive_in,
    input wire [NL-1:0] link_synced_out,
    input wire          dma_event_out
);
    // ==========
    // Helper counters
    reg [8:0] ev_cnt_q;
    reg [6:0] los_cnt_q;
    always @(posedge clock_in) begin
        if (rst_in || !timer_running_out) ev_cnt_q <= 9'h000;
        else if (frame_event_out) ev_cnt_q <= 9'h001;
        else if (ev_cnt_q != 9'h1ff) ev_cnt_q <= ev_cnt_q + 9'h001;
        if (rst_in || rx_clock_alive_in[0]) los_cnt_q <= 7'h00;
        else if (los_cnt_q != 7'h7f) los_cnt_q <= los_cnt_q + 7'h01;
    end
    // ==========
    // Properties
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    sequence s_burst_rise;
        $past(timer_enable_in, 2) && $rose(sync_burst_in);
    endsequence
    sequence s_burst_kept;
        (timer_enable_in && (resync_enable_in || !timer_running_out)) [*3];
    endsequence
    a_burst_event: assert property (s_burst_rise ##0 s_burst_kept |-> ##1 frame_event_out)
        else $error("no frame event after burst");
    a_event_run: assert property (frame_event_out |-> timer_running_out)
        else $error("frame event while not running");
    a_period_exact: assert property (frame_event_out && $past(timer_running_out) && !resync_enable_in |-> ev_cnt_q == 9'h100)
        else $error("frame period wrong");
    a_period_miss: assert property (timer_running_out && !resync_enable_in |-> ev_cnt_q <= 9'h100)
        else $error("frame event missing");
    a_dma_pass: assert property (frame_event_out && !cpu_reset_in && !$past(cpu_reset_in) && !$past(cpu_reset_in, 2) && !$past(cpu_reset_in, 3) |-> dma_event_out)
        else $error("dma event lost");
    a_dma_mask: assert property (cpu_reset_in && $past(cpu_reset_in) && $past(cpu_reset_in, 2) && $past(cpu_reset_in, 3) |-> !dma_event_out)
        else $error("dma event during reset");
    a_dma_only: assert property (dma_event_out |-> frame_event_out)
        else $error("dma event without frame");
    a_idle_off: assert property (!timer_enable_in [*2] |-> !timer_running_out)
        else $error("timer runs while disabled");
    a_los_drop: assert property (los_cnt_q == 7'h48 |-> !link_synced_out[0])
        else $error("dead link still synced");
    a_rx_off: assert property (!rx_enable_in[0] [*3] |-> !link_synced_out[0])
        else $error("disabled link still synced");
endmodule

// file: bench/alfc_remote.sv
// Remote node model: per-link frame marks, words and recovered clock presence.
// Assumes the bench drives the kill and skew masks at the rising edge.
`timescale 1ns/10ps
module alfc_remote #(
    parameter NL = 6,
    parameter DW = 32
) (
    input  wire             clock_in,
    input  wire [NL-1:0]    kill_in,
    input  wire [NL-1:0]    skew_in,
    output reg  [NL-1:0]    mark_out = '0,
    output reg  [NL-1:0]    valid_out = '0,
    output reg  [NL-1:0]    alive_out = '1,
    output reg  [NL*DW-1:0] data_out = '0
);
    // ==========
    // Link traffic
    reg [DW-1:0] cnt_q = '0;
    integer      i;
    always @(posedge clock_in) begin
        cnt_q <= cnt_q + 1'b1;
        for (i = 0; i < NL; i = i + 1) begin
            alive_out[i] <= !kill_in[i];
            mark_out[i] <= !kill_in[i] && !skew_in[i];
            valid_out[i] <= !kill_in[i];
            // A dead link toggles its lines, so a stale word cannot pass.
            data_out[i*DW +: DW] <= kill_in[i] ? ~data_out[i*DW +: DW] : cnt_q + i;
        end
    end
endmodule

// file: bench/tb.sv
// Self-checking bench for the link fault continuity top and a remote model.
// Assumes the design under core/ and the model and checker under bench/.
`timescale 1ns/10ps
module tb;
    reg           clock_in = 1'b0, rst_in = 1'b1, cpu_reset_in = 1'b0, comb_ready_in = 1'b0;
    reg           timer_enable_in = 1'b0, resync_enable_in = 1'b0, sync_burst_in = 1'b0;
    reg  [5:0]    rx_enable_in = 6'h3f, agg_nop_in = 6'h00, combine_sel_in = 6'h00;
    reg  [5:0]    tx_enable_in = 6'h3f;
    reg  [5:0]    kill = 6'h00, skew = 6'h00;
    reg  [191:0]  cpu_tx_data_in = 192'h0;
    wire          frame_event_out, timer_running_out, comb_valid_out, dma_event_out;
    wire [5:0]    rx_frame_mark_in, rx_word_valid_in, rx_clock_alive_in;
    wire [5:0]    link_synced_out, ram_write_out;
    wire [191:0]  rx_data_in, tx_data_out, ram_data_out;
    wire [31:0]   comb_data_out;
    int           errors = 0, n_checks = 0, ev_n = 0, ram_n = 0;
    bit           exp_q[$];
    bit           pass_prev = 1'b0;
    logic [191:0] rx_prev;
    alfc_top u_alfc_top (.*);
    alfc_remote u_alfc_remote (.clock_in(clock_in), .kill_in(kill), .skew_in(skew),
        .mark_out(rx_frame_mark_in), .valid_out(rx_word_valid_in),
        .alive_out(rx_clock_alive_in), .data_out(rx_data_in));
    initial forever #12.5 clock_in = ~clock_in;
    always @(negedge clock_in) begin
        if (ram_write_out[0] === 1'b1) begin
            ram_n++;
            check("ram data", ram_data_out[31:0], rx_prev[31:0]);
        end
        if (pass_prev) check("passthrough", tx_data_out[95:64], rx_prev[95:64]);
        // Outputs after the next edge reflect what stands now, so keep it.
        rx_prev = rx_data_in;
        pass_prev = combine_sel_in[2] && link_synced_out[2] && tx_enable_in[2];
        if (frame_event_out === 1'b1) begin
            ev_n++;
            if (exp_q.size() > 0) check("dma event", dma_event_out, exp_q.pop_front());
        end
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task test_done;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task frames(input int n, input bit dma);
        int k;
        k = ev_n + n;
        repeat (n) exp_q.push_back(dma);
        for (int t = 0; t < 300 * n && ev_n < k; t++) @(posedge clock_in);
        // One more edge, so that sync changes made by the last event are visible.
        @(posedge clock_in);
        if (ev_n < k) begin
            errors++;
            test_done();
        end
    endtask
    task burst;
        sync_burst_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        sync_burst_in <= 1'b0;
        @(posedge clock_in);
    endtask
    task cold;
        int e0;
        timer_enable_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        timer_enable_in <= 1'b1;
        e0 = ev_n;
        repeat (600) @(posedge clock_in);
        check("events before burst", ev_n - e0, 0);
        burst();
        frames(6, 1'b1);
        check("links synced", link_synced_out, 6'h3f);
    endtask
    initial begin
        int n;
        void'($urandom(32'h3bdc_4b9d));
        repeat (5) @(posedge clock_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        cold();
        cpu_tx_data_in <= {6{$urandom}};
        agg_nop_in <= 6'($urandom) | 6'h01;
        combine_sel_in <= 6'h04;
        comb_ready_in <= 1'b1;
        cpu_reset_in <= 1'b1;
        n = ram_n;
        repeat (4) @(posedge clock_in);
        frames(3, 1'b0);
        check("synced in reset", link_synced_out, 6'h3f);
        check("ram writes", ram_n > n + 3, 1);
        check("nop outbound", tx_data_out[31:0], 0);
        check("pass checks", pass_prev, 1);
        cpu_reset_in <= 1'b0;
        combine_sel_in <= 6'h00;
        repeat (4) @(posedge clock_in);
        frames(2, 1'b1);
        check("nop kept", tx_data_out[31:0], 0);
        agg_nop_in <= 6'h00;
        kill <= 6'h01;
        repeat (100) @(posedge clock_in);
        check("hot swap", link_synced_out, 6'h3e);
        kill <= 6'h00;
        frames(5, 1'b1);
        check("link back", link_synced_out, 6'h3f);
        skew <= 6'h02;
        frames(2, 1'b1);
        check("misaligned", link_synced_out, 6'h3d);
        skew <= 6'h00;
        frames(5, 1'b1);
        check("auto resync", link_synced_out, 6'h3f);
        rx_enable_in <= 6'h3e;
        tx_enable_in <= 6'h3d;
        repeat (4) @(posedge clock_in);
        check("rx off", link_synced_out, 6'h3e);
        check("tx off", tx_data_out[63:32], 0);
        check("tx on", tx_data_out[95:64], cpu_tx_data_in[95:64]);
        rx_enable_in <= 6'h3f;
        tx_enable_in <= 6'h3f;
        resync_enable_in <= 1'b1;
        burst();
        check("resync drop", link_synced_out, 6'h00);
        check("resync empty", tx_data_out[95:64], 0);
        resync_enable_in <= 1'b0;
        frames(5, 1'b1);
        check("offsets kept", link_synced_out, 6'h3f);
        tx_enable_in <= 6'h3e;
        kill <= 6'h01;
        repeat (100) @(posedge clock_in);
        combine_sel_in <= 6'h01;
        comb_ready_in <= 1'b0;
        // Slot 0 comes round every six cycles, so 32 fills need about 192 cycles.
        repeat (240) @(posedge clock_in);
        combine_sel_in <= 6'h00;
        tx_enable_in <= 6'h3f;
        repeat (4) @(posedge clock_in);
        comb_ready_in <= 1'b1;
        n = 0;
        repeat (100) begin
            @(negedge clock_in);
            if (comb_valid_out === 1'b1) begin
                n++;
                check("fill word", comb_data_out, 0);
            end
        end
        check("fifo depth", n, 32);
        @(posedge clock_in);
        kill <= 6'h00;
        cold();
        test_done();
    end
endmodule
bind alfc_top alfc_props #(.NL(NL)) u_alfc_props (.*);

// file: core/alfc_consts.vh
// Constants for the antenna link fault continuity block.
// Assumes a single 40 MHz clock and a power-on reset as the only reset.
// Functional notes
// - Only power-on reset clears state; processor reset leaves everything running.
// - Frame timer keeps counting and emitting events during processor reset.
// - Inbound links keep writing inbound RAM during processor reset.
// - Redirected or combined inbound traffic passes through processor reset untouched.
// - Per-link aggregator no-operation mode, restored to pre-reset value after reset.
// - Re-synchronization realigns timer to external burst; events restart at frame boundary.
// - Receive and transmit frame offsets stay valid after realignment.
// - While links resynchronize, send empty outbound data and decode nothing inbound.
// - Re-enabled timer waits for next sync burst and emits no events until then.
// - Outbound disables on its own; disabling inbound clears sync and so also empties outbound.
// - Frame misalignment triggers automatic re-synchronization without software.
// - Total failure of one link leaves other links running.
// - Failed link feeding combined stream gets empty messages until resynchronized.
// - Hot swap and recovered clock loss cause no lockup and no cross-link effect.
`ifndef ALFC_CONSTS_VH
`define ALFC_CONSTS_VH
`define ALFC_NUM_LINKS      6
`define ALFC_DATA_W         32
`define ALFC_FRAME_LEN      16'h0100
`define ALFC_SYNC_FRAMES    4'h2
`define ALFC_FIFO_DEPTH     32
`define ALFC_EMPTY_WORD     32'h0000_0000
`define ALFC_LOS_TIMEOUT    8'h40
`define ALFC_ST_IDLE        3'b001
`define ALFC_ST_WAIT        3'b010
`define ALFC_ST_RUN         3'b100
`endif

// file: core/alfc_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; reset is the power-on reset only.
`timescale 1ns/10ps
module alfc_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clock_in,
    input  wire             rst_in,
    input  wire [WIDTH-1:0] wr_data_in,
    input  wire             wr_valid_in,
    output wire             wr_ready_out,
    output wire [WIDTH-1:0] rd_data_out,
    output wire             rd_valid_out,
    input  wire             rd_ready_in
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wptr_q;
    reg [AW-1:0]    rptr_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;
    assign wr_ready_out = (cnt_q != DEPTH[AW:0]);
    assign rd_valid_out = (cnt_q != {(AW+1){1'b0}});
    assign rd_data_out  = mem_q[rptr_q];
    assign push = wr_valid_in & wr_ready_out;
    assign pop  = rd_valid_out & rd_ready_in;
    always @(posedge clock_in) begin
        if (push) begin
            mem_q[wptr_q] <= wr_data_in;
        end
    end
    always @(posedge clock_in) begin
        if (rst_in) begin
            wptr_q <= {AW{1'b0}};
            rptr_q <= {AW{1'b0}};
            cnt_q  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wptr_q <= (wptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= (rptr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// file: core/alfc_top.v
// Link fault continuity: frame timer, per-link sync tracking, combine with fill.
// Assumes rst_in is the power-on reset; processor reset arrives as a plain input.
`include "alfc_consts.vh"
`timescale 1ns/10ps
module alfc_top #(
    parameter NL    = `ALFC_NUM_LINKS,
    parameter DW    = `ALFC_DATA_W,
    parameter DEPTH = `ALFC_FIFO_DEPTH
) (
    input  wire             clock_in,
    input  wire             rst_in,
    input  wire             cpu_reset_in,
    input  wire             timer_enable_in,
    input  wire             resync_enable_in,
    input  wire             sync_burst_in,
    output reg              frame_event_out,
    output wire             timer_running_out,
    input  wire [NL-1:0]    rx_enable_in,
    input  wire [NL-1:0]    tx_enable_in,
    input  wire [NL-1:0]    agg_nop_in,
    input  wire [NL-1:0]    combine_sel_in,
    input  wire [NL-1:0]    rx_frame_mark_in,
    input  wire [NL-1:0]    rx_word_valid_in,
    input  wire [NL*DW-1:0] rx_data_in,
    input  wire [NL-1:0]    rx_clock_alive_in,
    input  wire [NL*DW-1:0] cpu_tx_data_in,
    output wire [NL-1:0]    link_synced_out,
    output reg  [NL*DW-1:0] tx_data_out,
    output reg  [NL-1:0]    ram_write_out,
    output reg  [NL*DW-1:0] ram_data_out,
    output wire [DW-1:0]    comb_data_out,
    output wire             comb_valid_out,
    input  wire             comb_ready_in,
    output wire             dma_event_out
);
    // ==========================================
    // Input synchronisers
    // ==========================================
    reg [NL+2:0] s1_q;
    reg [NL+2:0] s2_q;
    reg          burst_prev_q;
    always @(posedge clock_in) begin
        s1_q <= {sync_burst_in, rx_frame_mark_in, rx_clock_alive_in[0], cpu_reset_in};
        s2_q <= s1_q;
    end
    wire         cpu_rst   = s2_q[0];
    wire [NL-1:0] mark_s   = s2_q[NL+1:2];
    wire         burst_s   = s2_q[NL+2];
    wire         burst_rise = burst_s & ~burst_prev_q;
    reg  [NL-1:0] alive1_q;
    reg  [NL-1:0] alive2_q;
    always @(posedge clock_in) begin
        alive1_q <= rx_clock_alive_in;
        alive2_q <= alive1_q;
    end
    // ==========================================
    // Frame timer
    // ==========================================
    // Power-on only reset
    // Processor reset never reaches these registers, so state carries through it.
    reg [2:0]  tstate_q;
    reg [15:0] tcnt_q;
    always @(posedge clock_in) begin
        if (rst_in) begin
            tstate_q        <= `ALFC_ST_IDLE;
            tcnt_q          <= 16'h0000;
            burst_prev_q    <= 1'b0;
            frame_event_out <= 1'b0;
        end else begin
            burst_prev_q    <= burst_s;
            frame_event_out <= 1'b0;
            case (tstate_q)
                `ALFC_ST_IDLE: begin
                    if (timer_enable_in) begin
                        tstate_q <= `ALFC_ST_WAIT;
                    end
                end
                `ALFC_ST_WAIT: begin
                    if (!timer_enable_in) begin
                        tstate_q <= `ALFC_ST_IDLE;
                    end else if (burst_rise) begin
                        tstate_q        <= `ALFC_ST_RUN;
                        tcnt_q          <= 16'h0000;
                        frame_event_out <= 1'b1;
                    end
                end
                `ALFC_ST_RUN: begin
                    if (!timer_enable_in) begin
                        tstate_q <= `ALFC_ST_IDLE;
                    end else if (resync_enable_in && burst_rise) begin
                        tcnt_q          <= 16'h0000;
                        frame_event_out <= 1'b1;
                    end else if (tcnt_q == `ALFC_FRAME_LEN - 16'h0001) begin
                        tcnt_q          <= 16'h0000;
                        frame_event_out <= 1'b1;
                    end else begin
                        tcnt_q <= tcnt_q + 16'h0001;
                    end
                end
                default: begin
                    tstate_q <= `ALFC_ST_IDLE;
                end
            endcase
        end
    end
    assign timer_running_out = tstate_q[2];
    // Events to the DMA are held back while the processor is in reset.
    assign dma_event_out = frame_event_out & ~cpu_rst;
    wire resync_pulse = (tstate_q == `ALFC_ST_RUN) & resync_enable_in & burst_rise;
    // ==========================================
    // Per-link sync tracking and data paths
    // ==========================================
    // The mark check samples each link's mark on the frame event; the offsets live outside and are
    // never touched here, so they remain valid across a realignment.
    // Offsets stay valid
    genvar g;
    generate
        for (g = 0; g < NL; g = g + 1) begin : g_link
            reg [3:0] good_q;
            reg       sync_q;
            reg [7:0] los_q;
            wire      mark = mark_s[g];
            wire [DW-1:0] rxd = rx_data_in[g*DW +: DW];
            always @(posedge clock_in) begin
                if (rst_in) begin
                    good_q <= 4'h0;
                    sync_q <= 1'b0;
                    los_q  <= 8'h00;
                end else if (!rx_enable_in[g] || resync_pulse) begin
                    good_q <= 4'h0;
                    sync_q <= 1'b0;
                    los_q  <= 8'h00;
                end else begin
                    if (!alive2_q[g] && los_q != `ALFC_LOS_TIMEOUT) begin
                        los_q <= los_q + 8'h01;
                    end else if (alive2_q[g]) begin
                        los_q <= 8'h00;
                    end
                    if (los_q == `ALFC_LOS_TIMEOUT) begin
                        sync_q <= 1'b0;
                        good_q <= 4'h0;
                    end else if (frame_event_out) begin
                        if (mark) begin
                            if (good_q == `ALFC_SYNC_FRAMES) begin
                                sync_q <= 1'b1;
                            end else begin
                                good_q <= good_q + 4'h1;
                            end
                        end else begin
                            good_q <= 4'h0;
                            sync_q <= 1'b0;
                        end
                    end
                end
            end
            assign link_synced_out[g] = sync_q;
            always @(posedge clock_in) begin
                if (rst_in) begin
                    ram_write_out[g]          <= 1'b0;
                    ram_data_out[g*DW +: DW]  <= `ALFC_EMPTY_WORD;
                    tx_data_out[g*DW +: DW]   <= `ALFC_EMPTY_WORD;
                end else begin
                    ram_write_out[g]         <= sync_q & rx_word_valid_in[g];
                    ram_data_out[g*DW +: DW] <= rxd;
                    if (!tx_enable_in[g] || !sync_q) begin
                        tx_data_out[g*DW +: DW] <= `ALFC_EMPTY_WORD;
                    end else if (combine_sel_in[g]) begin
                        tx_data_out[g*DW +: DW] <= rxd;
                    end else if (agg_nop_in[g]) begin
                        tx_data_out[g*DW +: DW] <= `ALFC_EMPTY_WORD;
                    end else begin
                        tx_data_out[g*DW +: DW] <= cpu_tx_data_in[g*DW +: DW];
                    end
                end
            end
        end
    endgenerate
    // ==========================================
    // Combined stream with slot fill
    // ==========================================
    reg  [2:0]    slot_q;
    reg  [DW-1:0] slot_data;
    integer       i;
    always @* begin
        slot_data = `ALFC_EMPTY_WORD;
        for (i = 0; i < NL; i = i + 1) begin
            if (slot_q == i[2:0]) begin
                slot_data = link_synced_out[i] ? rx_data_in[i*DW +: DW] : `ALFC_EMPTY_WORD;
            end
        end
    end
    wire slot_ok = combine_sel_in[slot_q];
    wire push_rdy;
    // The slot walk stalls on a full FIFO so that no slot is skipped.
    always @(posedge clock_in) begin
        if (rst_in) begin
            slot_q <= 3'h0;
        end else if (push_rdy | ~slot_ok) begin
            slot_q <= (slot_q == NL - 1) ? 3'h0 : slot_q + 3'h1;
        end
    end
    alfc_fifo #(
        .WIDTH (DW),
        .DEPTH (DEPTH),
        .AW    (5)
    ) u_fifo (
        .clock_in     (clock_in),
        .rst_in       (rst_in),
        .wr_data_in   (slot_data),
        .wr_valid_in  (slot_ok),
        .wr_ready_out (push_rdy),
        .rd_data_out  (comb_data_out),
        .rd_valid_out (comb_valid_out),
        .rd_ready_in  (comb_ready_in)
    );
endmodule
